// ==== design/tcc_top.sv ====
/*
  Four-channel timer capture/compare control: indirect register port,
  channel control registers, event and overrun flags, interrupt requests.
  Assumes the counter, reload and prescaler live outside and deliver
  count_tick, timer_count, end_of_cycle and timer_run on core_clk.
  Register writes and reads are single-cycle strobes; read data appear one
  clock after reg_rd and hold until the next read. Channel outputs and
  interrupt requests leave from flops, so no glitch reaches the pins or the
  interrupt controller.
*/
// Summary of operation
// (R1) channel_on bit 7 enables the channel; zero disables it.
// (R2) one-shot: idle at polarity; enabled, inverts one clock on count match.
// (R3) continuous compare: idle at polarity; enabled, toggles on every match.
// (R4) pwm: idle low; high on match, low at reload or down-count match.
// (R5) capture on rising input edge for polarity 0, falling for polarity 1.
// (R6) interrupt request per event only while channel_irq_on is set.
// (R7) running with direct update off: value writes wait for end of cycle.
// (R8) timer stopped: value writes apply at once.
// (R9) mode 0 one-shot, 1 continuous, 2 pwm, 3 capture; 4-7 reserved.
// (R10) control bit 3 reads zero; software writes it zero.
// (R11) software sets polarity before enabling continuous compare or pwm.
// (R12) four control registers at subaddresses 02h-05h, subregister 2, reset zero.
// (R13) capture stores the 16-bit count into the high and low bytes.
// (R14) compare uses high byte above low byte against the count.
// (R15) event flag set per event, cleared by writing 1 or timer stop.
// (R16) overrun set on event with flag set; cleared with flag or stop.
// (R17) reserved mode codes: no action, output at disabled level.
`timescale 1ns/1ps
`default_nettype none
module tcc_top
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // indirect register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_subaddr,
  input wire logic [1:0] reg_subreg,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // timer counter side
  input wire logic timer_run,
  input wire logic count_tick,
  input wire logic [15:0] timer_count,
  input wire logic [15:0] timer_reload,
  input wire logic timer_updown,
  input wire logic count_down,
  input wire logic end_of_cycle,
  // channel pins
  input wire logic [3:0] chan_in,
  output logic [3:0] chan_out,
  // interrupt requests, one-cycle pulses
  output logic [3:0] chan_irq
);
  logic [7:0] ctrl_reg [4];
  logic [3:0] flag_reg;
  logic [3:0] overrun_reg;
  logic [3:0] event_w;
  logic [3:0] wr_high_w;
  logic [3:0] wr_low_w;
  logic [3:0] out_w;
  logic [7:0] high_w [4];
  logic [7:0] low_w [4];
  logic [3:0] clr_w;
  logic [7:0] rdata_next;
  logic [3:0] sel_w;
  logic ctrl_wr_w;
  logic [7:0] status_hi_w;
  logic [7:0] status_lo_w;

  // maps a subaddress to a one-hot channel select, zero if outside 02h-05h
  function automatic logic [3:0] chan_sel(input logic [7:0] sa);
    logic [3:0] s;
    s = 4'h0;
    if (sa >= tcc_pkg::ADDR_CHAN_FIRST && sa <= tcc_pkg::ADDR_CHAN_LAST)
      s = 4'h1 << (sa - tcc_pkg::ADDR_CHAN_FIRST); // [R12]
    return s;
  endfunction : chan_sel

  // one decoder shared by write strobes, control writes and the read mux,
  // so the range compare exists once instead of once per use
  assign sel_w = chan_sel(reg_subaddr);
  // control writes; the channel select qualifies them per slice
  assign ctrl_wr_w = reg_wr && (reg_subreg == tcc_pkg::SUBREG_CTRL);

  // write strobes and flag clear mask
  assign wr_high_w = (reg_wr && reg_subreg == tcc_pkg::SUBREG_HIGH) ?
                     sel_w : 4'h0;
  assign wr_low_w = (reg_wr && reg_subreg == tcc_pkg::SUBREG_LOW) ?
                    sel_w : 4'h0;
  // status clear mask: write-one-to-clear on the event flag byte
  assign clr_w = (reg_wr && reg_subreg == tcc_pkg::SUBREG_LOW &&
                  reg_subaddr == tcc_pkg::ADDR_STATUS) ? reg_wdata[3:0] : 4'h0;
  // status bytes; upper nibbles are reserved and read zero
  assign status_hi_w = {4'h0, overrun_reg}; // [R16]
  assign status_lo_w = {4'h0, flag_reg}; // [R15]

  // one slice per channel, A to D
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_chan
      // control register; reserved bit never stored, so a stray 1 from
      // software cannot come back on a read or reach the mode decode
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          ctrl_reg[i] <= tcc_pkg::CTRL_RESET; // [R12]
        else if (ctrl_wr_w && sel_w[i])
          ctrl_reg[i] <= reg_wdata & tcc_pkg::CTRL_WMASK; // [R10] [R12]
      end

      // per-channel datapath: value bytes, event detection, output flop
      tcc_chan u_chan
      (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .channel_on(ctrl_reg[i][tcc_pkg::BIT_ON]), // [R1]
        .channel_polarity(ctrl_reg[i][tcc_pkg::BIT_POL]),
        .channel_direct_update(ctrl_reg[i][tcc_pkg::BIT_DIRECT]),
        .channel_op_mode(ctrl_reg[i][tcc_pkg::MODE_MSB:0]),
        .timer_run(timer_run),
        .count_tick(count_tick),
        .timer_count(timer_count),
        .timer_reload(timer_reload),
        .timer_updown(timer_updown),
        .count_down(count_down),
        .end_of_cycle(end_of_cycle),
        .wr_high(wr_high_w[i]),
        .wr_low(wr_low_w[i]),
        .wdata(reg_wdata),
        .chan_in(chan_in[i]),
        .chan_out(out_w[i]),
        .chan_event(event_w[i]),
        .high_byte(high_w[i]),
        .low_byte(low_w[i])
      );

      // event flag: set wins over a write-one clear, so an event landing on
      // the clear cycle is never lost; a stopped timer beats both, which
      // keeps stale flags from outliving the count
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          flag_reg[i] <= 1'b0;
        else if (!timer_run)
          flag_reg[i] <= 1'b0; // [R15]
        else if (event_w[i])
          flag_reg[i] <= 1'b1; // [R15]
        else if (clr_w[i])
          flag_reg[i] <= 1'b0; // [R15]
      end

      // overrun: a second event before the flag is cleared; a clear in the
      // same cycle drops it, as software has just taken the earlier event
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          overrun_reg[i] <= 1'b0;
        else if (!timer_run)
          overrun_reg[i] <= 1'b0; // [R16]
        else if (event_w[i] && flag_reg[i] && !clr_w[i])
          overrun_reg[i] <= 1'b1; // [R16]
        else if (clr_w[i])
          overrun_reg[i] <= 1'b0; // [R16]
      end

      // irq pulse follows the event by one clock
      // masked events still set the flag; only the request is gated
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          chan_irq[i] <= 1'b0;
        else
          chan_irq[i] <= event_w[i] && ctrl_reg[i][tcc_pkg::BIT_IRQ_ON]; // [R6]
      end
    end
  endgenerate

  // channel outputs are already flops inside each channel; retime skipped
  // to keep the match-to-pin delay at one clock
  assign chan_out = out_w;

  // read mux; unmapped subaddresses read zero
  // the status subaddress lies outside the channel range, so they never overlap
  always_comb
  begin
    rdata_next = 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      if (sel_w[k])
      begin
        case (reg_subreg)
          tcc_pkg::SUBREG_HIGH: rdata_next = high_w[k];
          tcc_pkg::SUBREG_LOW: rdata_next = low_w[k];
          tcc_pkg::SUBREG_CTRL: rdata_next = ctrl_reg[k]; // [R10]
          default: rdata_next = 8'h00;
        endcase
      end
    end
    if (reg_subaddr == tcc_pkg::ADDR_STATUS)
    begin
      if (reg_subreg == tcc_pkg::SUBREG_HIGH)
        rdata_next = status_hi_w;
      else if (reg_subreg == tcc_pkg::SUBREG_LOW)
        rdata_next = status_lo_w;
    end
  end

  // read data registered; held between reads
  // so a slow reader sees a stable byte until its next strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end
endmodule : tcc_top
`default_nettype wire

// ==== design/tcc_pkg.sv ====
/*
  Shared constants for the four-channel timer capture/compare control block:
  subaddress map, control field positions, mode codes and reset values.
  Assumes an 8-bit indirect register port and a 16-bit timer counter outside.
*/
package tcc_pkg;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned CNT_W = 16;
  // subregister selects
  localparam logic [1:0] SUBREG_HIGH = 2'h0;
  localparam logic [1:0] SUBREG_LOW = 2'h1;
  localparam logic [1:0] SUBREG_CTRL = 2'h2;
  // subaddresses
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_CHAN_FIRST = 8'h02;
  localparam logic [7:0] ADDR_CHAN_LAST = 8'h05;
  // channel_control_reg fields
  localparam int unsigned BIT_ON = 7;
  localparam int unsigned BIT_POL = 6;
  localparam int unsigned BIT_IRQ_ON = 5;
  localparam int unsigned BIT_DIRECT = 4;
  localparam int unsigned BIT_RSVD = 3;
  localparam int unsigned MODE_MSB = 2;
  localparam logic [7:0] CTRL_WMASK = 8'hF7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  // channel_op_mode codes
  localparam logic [2:0] MODE_ONESHOT = 3'h0;
  localparam logic [2:0] MODE_CONT = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_CAPTURE = 3'h3;
endpackage : tcc_pkg

// ==== design/tcc_chan.sv ====
/*
  One capture/compare channel: value bytes with deferred-load buffer,
  compare/capture event detection and the channel output flop.
  Assumes timer_count is valid in the cycle count_tick pulses and that
  end_of_cycle is a one-cycle pulse at the timer end count.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_chan
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control fields
  input wire logic channel_on,
  input wire logic channel_polarity,
  input wire logic channel_direct_update,
  input wire logic [2:0] channel_op_mode,
  // timer side
  input wire logic timer_run,
  input wire logic count_tick,
  input wire logic [15:0] timer_count,
  input wire logic [15:0] timer_reload,
  input wire logic timer_updown,
  input wire logic count_down,
  input wire logic end_of_cycle,
  // byte writes
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  // channel pins and results
  input wire logic chan_in,
  output logic chan_out,
  output logic chan_event,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  logic [7:0] high_reg;
  logic [7:0] low_reg;
  logic [7:0] high_buf_reg;
  logic [7:0] low_buf_reg;
  logic high_pend_reg;
  logic low_pend_reg;
  logic in_prev_reg;
  logic out_reg;
  logic match;
  logic capture_edge;
  logic defer;
  logic is_cmp_mode;

  assign high_byte = high_reg;
  assign low_byte = low_reg;
  assign chan_out = out_reg;
  // writes are deferred only while running without direct update
  assign defer = timer_run && !channel_direct_update; // [R7] [R8]
  assign is_cmp_mode = (channel_op_mode == tcc_pkg::MODE_ONESHOT) ||
                       (channel_op_mode == tcc_pkg::MODE_CONT) ||
                       (channel_op_mode == tcc_pkg::MODE_PWM); // [R9] [R17]
  // match on the tick only, so a prescaled count held for many clocks fires once
  assign match = channel_on && timer_run && count_tick && is_cmp_mode &&
                 (timer_count == {high_reg, low_reg}); // [R14]
  // rising edge for polarity 0, falling for polarity 1
  assign capture_edge = channel_on && timer_run &&
                        (channel_op_mode == tcc_pkg::MODE_CAPTURE) &&
                        (chan_in != in_prev_reg) &&
                        (chan_in == !channel_polarity); // [R5]

  // input history for edge detection
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      in_prev_reg <= 1'b0;
    else
      in_prev_reg <= chan_in;
  end

  // event strobe to the flag logic
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      chan_event <= 1'b0;
    else
      chan_event <= match || capture_edge;
  end

  // value bytes: capture beats a software write in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      high_reg <= tcc_pkg::BYTE_RESET;
      low_reg <= tcc_pkg::BYTE_RESET;
      high_buf_reg <= tcc_pkg::BYTE_RESET;
      low_buf_reg <= tcc_pkg::BYTE_RESET;
      high_pend_reg <= 1'b0;
      low_pend_reg <= 1'b0;
    end
    else if (capture_edge)
    begin
      high_reg <= timer_count[15:8]; // [R13]
      low_reg <= timer_count[7:0]; // [R13]
    end
    else
    begin
      if (wr_high && defer)
      begin
        high_buf_reg <= wdata; // [R7]
        high_pend_reg <= 1'b1;
      end
      else if (wr_high)
      begin
        high_reg <= wdata; // [R8]
        high_pend_reg <= 1'b0;
      end
      else if (high_pend_reg && (end_of_cycle || !defer))
      begin
        high_reg <= high_buf_reg; // [R7]
        high_pend_reg <= 1'b0;
      end
      if (wr_low && defer)
      begin
        low_buf_reg <= wdata; // [R7]
        low_pend_reg <= 1'b1;
      end
      else if (wr_low)
      begin
        low_reg <= wdata; // [R8]
        low_pend_reg <= 1'b0;
      end
      else if (low_pend_reg && (end_of_cycle || !defer))
      begin
        low_reg <= low_buf_reg; // [R7]
        low_pend_reg <= 1'b0;
      end
    end
  end

  // channel output per mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      out_reg <= 1'b0;
    else if (!channel_on)
    begin
      // pwm idles low; every other mode idles at polarity
      if (channel_op_mode == tcc_pkg::MODE_PWM)
        out_reg <= 1'b0; // [R4]
      else
        out_reg <= channel_polarity; // [R2] [R3] [R17]
    end
    else
    begin
      case (channel_op_mode)
        tcc_pkg::MODE_ONESHOT: out_reg <= channel_polarity ^ match; // [R2]
        tcc_pkg::MODE_CONT: out_reg <= out_reg ^ match; // [R3]
        tcc_pkg::MODE_PWM:
        begin
          if (match && !(timer_updown && count_down))
            out_reg <= 1'b1; // [R4]
          else if (timer_run && count_tick && !timer_updown &&
                   (timer_count == timer_reload))
            out_reg <= 1'b0; // [R4]
          else if (match)
            out_reg <= 1'b0; // [R4]
        end
        default: out_reg <= channel_polarity; // [R17]
      endcase
    end
  end
endmodule : tcc_chan
`default_nettype wire

// ==== verification/tcc_asserts.sv ====
/* port checker for tcc_top
   assumes channel A carries the output tests */
`timescale 1ns/1ps
`default_nettype none
module tcc_asserts
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_subaddr,
  input wire logic [1:0] reg_subreg,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // timer and channels
  input wire logic timer_run,
  input wire logic count_tick,
  input wire logic [3:0] chan_out,
  input wire logic [3:0] chan_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ctl_a;
  logic ctl_wr;
  // shadow of channel A control; bit 3 never stored
  assign ctl_wr = reg_wr && reg_subaddr == 8'h02 && reg_subreg == 2'h2;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ctl_a <= 8'h00;
    else if (ctl_wr)
      ctl_a <= reg_wdata & 8'hF7;
  end
  property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rsvd; reg_rd && reg_subreg == 2'h2 |=> !reg_rdata[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_stop; !timer_run [*2] |=> chan_irq == 4'h0; endproperty
  a_stop: assert property (p_stop) else $error("irq while stopped");
  property p_pwm_idle; $stable(ctl_a) && ctl_a[7:6] != 2'h3 && !ctl_a[7] && ctl_a[2:0] == 3'h2
    |-> !chan_out[0]; endproperty
  a_pwm_idle: assert property (p_pwm_idle) else $error("pwm idle not low");
  // disabled one-shot and continuous modes and reserved modes sit at polarity
  property p_idle; $stable(ctl_a) && (ctl_a[2] || (!ctl_a[7] && !ctl_a[1]))
    |-> chan_out[0] == ctl_a[6]; endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_irq_en; chan_irq[0] |-> ctl_a[5] || $past(ctl_a[5]) || $past(ctl_a[5], 2);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while masked");
  property p_cont; $stable(ctl_a) && ctl_a[7] && ctl_a[2:0] == 3'h1 && $changed(chan_out[0])
    |-> $past(count_tick) && $past(timer_run); endproperty
  a_cont: assert property (p_cont) else $error("toggle without tick");
  property p_one; $stable(ctl_a) && ctl_a[7] && ctl_a[2:0] == 3'h0 && chan_out[0] != ctl_a[6]
    |=> chan_out[0] == ctl_a[6]; endproperty
  a_one: assert property (p_one) else $error("one-shot too long");
  c_irq: cover property (chan_irq[0]);
  c_pwm_high: cover property (ctl_a[7] && ctl_a[2:0] == 3'h2 && chan_out[0]);
  c_status_rd: cover property (reg_rd && reg_subaddr == 8'h01);
endmodule : tcc_asserts
`default_nettype wire

// ==== verification/tcc_pin_model.sv ====
/* pin model driving the channel inputs
   assumes the bench sets requested levels off the rising edge */
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model
(
  // clock
  input wire logic core_clk,
  // requested level and pins
  input wire logic [3:0] pin_lvl,
  output logic [3:0] chan_in
);
  // pins move by nonblocking update on the rising edge, so the design
  // sees the new level one edge later with no race against the bench
  always_ff @(posedge core_clk)
    chan_in <= pin_lvl;
endmodule : tcc_pin_model
`default_nettype wire

// ==== verification/tb_timer_channel_capture_compare.sv ====
/* self-checking bench for tcc_top
   assumes read data one edge after the strobe */
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_capture_compare;
  logic core_clk, rst_n, reg_wr, reg_rd, timer_run, count_tick, timer_updown, count_down;
  logic end_of_cycle, rd_q;
  logic [7:0] reg_subaddr, reg_wdata, reg_rdata, r;
  logic [1:0] reg_subreg;
  logic [15:0] timer_count, timer_reload, cap;
  logic [3:0] chan_in, chan_out, chan_irq, pin_lvl;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int n_compared = 0;
  tcc_top DUT
  (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_subaddr(reg_subaddr), .reg_subreg(reg_subreg), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .timer_run(timer_run), .count_tick(count_tick),
    .timer_count(timer_count), .timer_reload(timer_reload), .timer_updown(timer_updown),
    .count_down(count_down), .end_of_cycle(end_of_cycle), .chan_in(chan_in),
    .chan_out(chan_out), .chan_irq(chan_irq)
  );
  tcc_pin_model pins (.core_clk(core_clk), .pin_lvl(pin_lvl), .chan_in(chan_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [1:0] s, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_subaddr = a;
    reg_subreg = s;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    reg_rd = 1'b1;
    reg_subaddr = a;
    reg_subreg = s;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
  endtask : rd
  // one count tick, then channel A output checked one edge later
  task automatic tk(input logic [15:0] c, input logic e);
    count_tick = 1'b1;
    timer_count = c;
    @(negedge core_clk);
    count_tick = 1'b0;
    chk(8'(chan_out[0]), 8'(e));
    @(negedge core_clk);
  endtask : tk
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // read data checked half a cycle after it lands
  always @(posedge core_clk)
    rd_q <= reg_rd;
  always @(negedge core_clk)
    if (rd_q === 1'b1)
      chk(reg_rdata, exp_q.pop_front());
  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, timer_run, count_tick, timer_updown, count_down} = '0;
    {end_of_cycle, reg_subaddr, reg_subreg, reg_wdata, timer_count, timer_reload} = '0;
    pin_lvl = 4'h0;
    void'($urandom(32'hD3746065));
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 2; i < 7; i++)
    begin
      rd(8'(i), 2'h2, 8'h00);
      r = (8'($urandom) & 8'h7F) | 8'h08;
      wr(8'(i), 2'h2, r);
      rd(8'(i), 2'h2, (i < 6) ? (r & 8'hF7) : 8'h00);
      wr(8'(i), 2'h2, 8'h00);
    end
    $display("registers done");
    wr(8'h02, 2'h0, 8'h12);
    wr(8'h02, 2'h1, 8'h34);
    rd(8'h02, 2'h1, 8'h34);
    wr(8'h02, 2'h2, 8'h41); // polarity before enable
    wr(8'h02, 2'h2, 8'hE1);
    timer_run = 1'b1;
    tk(16'h1233, 1'b1);
    tk(16'h1234, 1'b0);
    chk(8'(chan_irq), 8'h01);
    rd(8'h01, 2'h1, 8'h01);
    tk(16'h1234, 1'b1);
    rd(8'h01, 2'h0, 8'h01);
    wr(8'h01, 2'h1, 8'h01);
    rd(8'h01, 2'h1, 8'h00);
    rd(8'h01, 2'h0, 8'h00);
    wr(8'h02, 2'h1, 8'h56);
    tk(16'h1256, 1'b1); // held in buffer
    tk(16'h1234, 1'b0);
    end_of_cycle = 1'b1;
    @(negedge core_clk);
    end_of_cycle = 1'b0;
    wr(8'h02, 2'h2, 8'hC1);
    tk(16'h1256, 1'b1);
    chk(8'(chan_irq), 8'h00);
    $display("compare done");
    wr(8'h02, 2'h2, 8'h00);
    wr(8'h01, 2'h1, 8'h0F);
    wr(8'h03, 2'h2, 8'h83);
    cap = 16'($urandom);
    tk(cap, 1'b0);
    pin_lvl[1] = 1'b1;
    tk(~cap, 1'b0);
    pin_lvl[1] = 1'b0;
    wr(8'h03, 2'h2, 8'hC3);
    pin_lvl[1] = 1'b1;
    tk(cap ^ 16'h00FF, 1'b0);
    pin_lvl[1] = 1'b0;
    repeat (3) @(negedge core_clk);
    rd(8'h03, 2'h0, cap[15:8]);
    rd(8'h03, 2'h1, cap[7:0] ^ 8'hFF);
    rd(8'h01, 2'h1, 8'h02);
    rd(8'h01, 2'h0, 8'h02);
    $display("capture done");
    wr(8'h02, 2'h2, 8'h52);
    wr(8'h02, 2'h0, 8'h00);
    wr(8'h02, 2'h1, 8'h10); // direct update
    wr(8'h02, 2'h2, 8'hD2);
    timer_reload = 16'h0020;
    tk(16'h0010, 1'b1);
    tk(16'h0020, 1'b0);
    timer_updown = 1'b1;
    tk(16'h0010, 1'b1);
    count_down = 1'b1;
    tk(16'h0010, 1'b0);
    {timer_updown, count_down} = 2'h0;
    $display("pwm done");
    for (int m = 0; m < 8; m++)
    begin
      if (m == 2 || m == 3)
        continue;
      wr(8'h02, 2'h2, 8'h40 | 8'(m));
      wr(8'h02, 2'h2, 8'hC0 | 8'(m));
      tk(16'h0010, (m < 2) ? 1'b0 : 1'b1);
      chk(8'(chan_out[0]), (m == 1) ? 8'h00 : 8'h01);
    end
    timer_run = 1'b0;
    repeat (2) @(negedge core_clk);
    rd(8'h01, 2'h1, 8'h00);
    rd(8'h01, 2'h0, 8'h00);
    $display("modes done");
    repeat (2) @(negedge core_clk);
    stop_test();
  end
endmodule : tb_timer_channel_capture_compare
bind tcc_top tcc_asserts u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_subaddr(reg_subaddr), .reg_subreg(reg_subreg), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .timer_run(timer_run), .count_tick(count_tick),
  .chan_out(chan_out), .chan_irq(chan_irq)
);
`default_nettype wire
